// >>> include/isro_pkg.sv
// constants, types and register map of the image sensor readout block
package isro_pkg;
	// ------------------------------------------------------------
	// frame geometry and rates
	// ------------------------------------------------------------
	localparam int unsigned ACTIVE_ROWS = 1080;
	localparam int unsigned ACTIVE_COLS = 1920;
	localparam int unsigned VBLANK_ROWS = 45;
	localparam int unsigned EMB_ROWS = 2;
	localparam int unsigned FRAME_RATE_FPS = 60;
	localparam int unsigned WORD_BITS = 12;
	localparam int unsigned LANES = 4;
	localparam longint LINK_HZ_DEF = 445_500_000;
	localparam longint OUT_CLK_MAX_HZ = 74_250_000;
	localparam longint PIX_RATE_MAX_HZ = 148_500_000;
	localparam longint MCLK_MIN_HZ = 6_000_000;
	localparam longint MCLK_MAX_HZ = 48_000_000;
	// link cycles per parallel pixel, and per four-pixel serial group
	localparam int unsigned PAR_DIV = int'((LINK_HZ_DEF + OUT_CLK_MAX_HZ - 1) / OUT_CLK_MAX_HZ);
	localparam int unsigned SER_RATE_CYC =
		int'((LANES * LINK_HZ_DEF + PIX_RATE_MAX_HZ - 1) / PIX_RATE_MAX_HZ);
	localparam int unsigned SER_GROUP = (SER_RATE_CYC > WORD_BITS) ? SER_RATE_CYC : WORD_BITS;
	localparam int unsigned PAR_LOAD = 2;
	localparam int unsigned PAR_RISE = PAR_DIV / 2;
	localparam int unsigned ROW_RST_COL = 1;
	localparam int unsigned ROW_LEN_DEF =
		int'(LINK_HZ_DEF / (FRAME_RATE_FPS * (ACTIVE_ROWS + VBLANK_ROWS)));
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_EXPOSURE = 8'h04;
	localparam logic [7:0] REG_GAIN = 8'h08;
	localparam logic [7:0] REG_ROWLEN = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam int unsigned GAIN_FRAC = 7;
	localparam logic [8:0] GAIN_RST = 9'h080;
	localparam logic [10:0] EXP_LONG_RST = 11'h3E8;
	localparam logic [10:0] EXP_SHORT_RST = 11'h064;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic raise_cm;
		logic pll_en;
		logic embed;
		logic parallel;
		logic comp10;
		logic hdr;
		logic trig_mode;
		logic run;
	} isro_ctrl_s;
	typedef struct packed {
		isro_ctrl_s ctrl;
		logic [10:0] exp_long;
		logic [10:0] exp_short;
		logic [8:0] gain;
		logic [11:0] offset;
		logic [15:0] row_len;
	} isro_cfg_s;
	localparam isro_ctrl_s CTRL_RST = '{run: 1'b1, pll_en: 1'b1, default: 1'b0};
	localparam isro_cfg_s CFG_RST = '{ctrl: CTRL_RST, exp_long: EXP_LONG_RST,
		exp_short: EXP_SHORT_RST, gain: GAIN_RST, offset: 12'h000,
		row_len: 16'(ROW_LEN_DEF)};
	typedef enum logic {ST_IDLE, ST_RUN} isro_st_e;
	typedef enum logic [1:0] {ROW_TOP, ROW_DATA, ROW_BOT, ROW_BLANK} isro_row_e;
endpackage : isro_pkg

// >>> logic/isro_top.sv
// image sensor readout sequencer, pixel path and output ports with ahb-lite registers
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module isro_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic link_clk,
	input wire logic trigger_pin,
	input wire logic output_enable_n,
	input wire logic [isro_pkg::WORD_BITS-1:0] adc_sample,
	output logic adc_take,
	output logic row_reset_pulse,
	output logic [10:0] row_reset_addr,
	output logic row_read_pulse,
	output logic [10:0] row_read_addr,
	output logic hdr_second,
	output logic [isro_pkg::WORD_BITS-1:0] par_data,
	output logic par_oe,
	output logic parallel_pixel_clock,
	output logic frame_active,
	output logic row_active,
	output logic [isro_pkg::LANES-1:0] serial_data_lane_pos,
	output logic [isro_pkg::LANES-1:0] serial_data_lane_neg,
	output logic serial_lane_clock_pos,
	output logic serial_lane_clock_neg,
	output logic pll_enable,
	output logic raised_common_mode_select
);
	import isro_pkg::*;

	// ------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// ------------------------------------------------------------
	isro_cfg_s cfg_bus, next_cfg, xfer, l_cfg;
	logic ap_v, ap_wr, dirty, req_t, ack_t, ack_m, ack_s, pending;
	logic [7:0] ap_addr;
	logic [15:0] fgray, fg_m, fg_s, fcnt_h;
	logic cfg_write;

	assign cfg_write = ap_v && ap_wr && (ap_addr != REG_STATUS);
	assign pending = (req_t != ack_s);

	always_comb begin
		next_cfg = cfg_bus;
		if (ap_v && ap_wr) begin
			case (ap_addr)
				REG_CTRL: next_cfg.ctrl = hwdata[7:0];
				REG_EXPOSURE: begin
					next_cfg.exp_long = hwdata[10:0];
					next_cfg.exp_short = hwdata[26:16];
				end
				REG_GAIN: begin
					next_cfg.gain = hwdata[8:0];
					next_cfg.offset = hwdata[27:16];
				end
				REG_ROWLEN: next_cfg.row_len = hwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		fcnt_h = 16'h0000;
		fcnt_h[15] = fg_s[15];
		for (int i = 14; i >= 0; i--) begin
			fcnt_h[i] = fcnt_h[i+1] ^ fg_s[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_v <= 1'b0;
			ap_wr <= 1'b0;
			ap_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (hready) begin
			ap_v <= hsel && htrans[1] && (hsize == 3'b010);
			ap_wr <= hwrite;
			ap_addr <= haddr[7:0];
			hrdata <= 32'h0000_0000;
			if (hsel && htrans[1] && !hwrite) begin
				case (haddr[7:0])
					REG_CTRL: hrdata <= {24'h00_0000, next_cfg.ctrl};
					REG_EXPOSURE: hrdata <= {5'h00, next_cfg.exp_short, 5'h00, next_cfg.exp_long};
					REG_GAIN: hrdata <= {4'h0, next_cfg.offset, 7'h00, next_cfg.gain};
					REG_ROWLEN: hrdata <= {16'h0000, next_cfg.row_len};
					// in flight from the accepted write until the link side acknowledges
					REG_STATUS: hrdata <= {15'h0000, pending || dirty || cfg_write, fcnt_h};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// register writes, then a word handshake carries them to the link side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_bus <= CFG_RST;
			xfer <= CFG_RST;
			dirty <= 1'b0;
			req_t <= 1'b0;
		end else begin
			cfg_bus <= next_cfg;
			if (dirty && !pending) begin
				xfer <= cfg_bus;
				req_t <= ~req_t;
			end
			// a write in the launch cycle keeps the flag set
			dirty <= cfg_write || (dirty && pending);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ack_m <= 1'b0;
			ack_s <= 1'b0;
			fg_m <= 16'h0000;
			fg_s <= 16'h0000;
		end else begin
			ack_m <= ack_t;
			ack_s <= ack_m;
			fg_m <= fgray;
			fg_s <= fg_m;
		end
	end

	// ------------------------------------------------------------
	// link domain: reset release, synchronisers, config capture
	// ------------------------------------------------------------
	logic lrst_m, lrst_n, req_m, req_s, req_d;
	logic trig_m, trig_s, trig_d, oe_m, oe_s;

	always_ff @(posedge link_clk or negedge hresetn) begin
		if (!hresetn) begin
			lrst_m <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_m <= 1'b1;
			lrst_n <= lrst_m;
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			req_d <= 1'b0;
			trig_m <= 1'b0;
			trig_s <= 1'b0;
			trig_d <= 1'b0;
			oe_m <= 1'b1;
			oe_s <= 1'b1;
		end else begin
			req_m <= req_t;
			req_s <= req_m;
			req_d <= req_s;
			trig_m <= trigger_pin;
			trig_s <= trig_m;
			trig_d <= trig_s;
			oe_m <= output_enable_n;
			oe_s <= oe_m;
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			l_cfg <= CFG_RST;
			ack_t <= 1'b0;
		end else if (req_s != req_d) begin
			l_cfg <= xfer;
			ack_t <= req_s;
		end
	end

	assign pll_enable = l_cfg.ctrl.pll_en;
	assign raised_common_mode_select = l_cfg.ctrl.raise_cm;

	// ------------------------------------------------------------
	// frame and row sequencer
	// ------------------------------------------------------------
	isro_st_e st;
	isro_row_e kind;
	logic [15:0] col;
	logic [11:0] slot, emb, dslots, nslots, rel, rst_sum;
	logic [10:0] arr_row, exp_sel;
	logic sub, row_end, frame_end, trig_edge, pix_row;
	logic [15:0] frame_cnt, next_fcnt;

	assign trig_edge = trig_s && !trig_d;
	assign emb = l_cfg.ctrl.embed ? 12'(EMB_ROWS) : 12'h000;
	assign dslots = l_cfg.ctrl.hdr ? 12'(2 * ACTIVE_ROWS) : 12'(ACTIVE_ROWS);
	assign nslots = 12'(dslots + emb + emb + 12'(VBLANK_ROWS));
	assign rel = 12'(slot - emb);
	assign arr_row = l_cfg.ctrl.hdr ? rel[11:1] : rel[10:0];
	assign sub = l_cfg.ctrl.hdr && rel[0];
	assign exp_sel = sub ? l_cfg.exp_short : l_cfg.exp_long;
	assign rst_sum = 12'({1'b0, arr_row} + {1'b0, exp_sel});
	assign row_end = (col == 16'(l_cfg.row_len - 16'h0001));
	assign frame_end = row_end && (slot == 12'(nslots - 12'h001));
	assign pix_row = (st == ST_RUN) && (kind != ROW_BLANK);
	assign next_fcnt = 16'(frame_cnt + 16'h0001);

	always_comb begin
		if (slot < emb) kind = ROW_TOP;
		else if (slot < 12'(emb + dslots)) kind = ROW_DATA;
		else if (slot < 12'(emb + emb + dslots)) kind = ROW_BOT;
		else kind = ROW_BLANK;
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			st <= ST_IDLE;
			col <= 16'h0000;
			slot <= 12'h000;
			frame_cnt <= 16'h0000;
			fgray <= 16'h0000;
		end else begin
			case (st)
				ST_IDLE: begin
					col <= 16'h0000;
					slot <= 12'h000;
					if (l_cfg.ctrl.trig_mode ? trig_edge : l_cfg.ctrl.run) st <= ST_RUN;
				end
				ST_RUN: begin
					col <= row_end ? 16'h0000 : 16'(col + 16'h0001);
					if (frame_end) begin
						slot <= 12'h000;
						frame_cnt <= next_fcnt;
						fgray <= next_fcnt ^ (next_fcnt >> 1);
						if (l_cfg.ctrl.trig_mode || !l_cfg.ctrl.run) st <= ST_IDLE;
					end else if (row_end) begin
						slot <= 12'(slot + 12'h001);
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// row read at the start of each data slot, reset of the row exposure rows ahead
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			row_read_pulse <= 1'b0;
			row_read_addr <= 11'h000;
			hdr_second <= 1'b0;
			row_reset_pulse <= 1'b0;
			row_reset_addr <= 11'h000;
		end else begin
			row_read_pulse <= (st == ST_RUN) && (kind == ROW_DATA) && (col == 16'h0000);
			row_reset_pulse <= (st == ST_RUN) && (kind == ROW_DATA)
				&& (col == 16'(ROW_RST_COL));
			if ((st == ST_RUN) && (kind == ROW_DATA) && (col == 16'h0000)) begin
				row_read_addr <= arr_row;
				hdr_second <= sub;
			end
			if ((st == ST_RUN) && (kind == ROW_DATA) && (col == 16'(ROW_RST_COL))) begin
				row_reset_addr <= (rst_sum >= 12'(ACTIVE_ROWS)) ?
					11'(rst_sum - 12'(ACTIVE_ROWS)) : rst_sum[10:0];
			end
		end
	end

	// ------------------------------------------------------------
	// pixel fetch and digital path
	// ------------------------------------------------------------
	logic [2:0] pdiv;
	logic [3:0] gcyc;
	logic [10:0] px, t_px;
	logic need, t_v, t_emb, t_bot, t_fr, v2, fr2, d2;
	logic [1:0] t_lane, lane2;
	logic [11:0] w2, lin2, proc_w, emb_w;
	logic [19:0] hist [4];
	logic [19:0] hist_snap [4];
	logic [23:0] item;

	assign need = pix_row && (px < 11'(ACTIVE_COLS))
		&& (l_cfg.ctrl.parallel ? (pdiv == 3'h0) : (gcyc < 4'(LANES)));

	function automatic logic [11:0] gain_path(input logic [11:0] s, input logic [11:0] ofs,
			input logic [8:0] g);
		logic [11:0] c;
		logic [20:0] p;
		c = (s > ofs) ? 12'(s - ofs) : 12'h000;
		p = 21'(c) * 21'(g);
		return (p[20:GAIN_FRAC] > 14'h0FFF) ? 12'hFFF : p[GAIN_FRAC+11:GAIN_FRAC];
	endfunction : gain_path

	// piecewise compression of 12-bit into 10-bit codes
	function automatic logic [11:0] compress(input logic [11:0] x);
		if (x < 12'h200) return x;
		else if (x < 12'h400) return 12'(12'h200 + ((x - 12'h200) >> 1));
		else if (x < 12'h800) return 12'(12'h300 + ((x - 12'h400) >> 3));
		else return 12'(12'h380 + ((x - 12'h800) >> 4));
	endfunction : compress

	always_comb begin
		case (t_px[3:1])
			3'h0: item = t_bot ? {4'h0, hist_snap[0]} : {16'h0000, l_cfg.ctrl};
			3'h1: item = t_bot ? {4'h0, hist_snap[1]} : {13'h0000, l_cfg.exp_long};
			3'h2: item = t_bot ? {4'h0, hist_snap[2]} : {13'h0000, l_cfg.exp_short};
			3'h3: item = t_bot ? {4'h0, hist_snap[3]} : {15'h0000, l_cfg.gain};
			3'h4: item = t_bot ? 24'h00_0000 : {12'h000, l_cfg.offset};
			3'h5: item = t_bot ? 24'h00_0000 : {8'h00, l_cfg.row_len};
			3'h6: item = {8'h00, frame_cnt};
			default: item = 24'h00_0000;
		endcase
	end

	assign emb_w = t_px[0] ? item[11:0] : item[23:12];
	assign proc_w = gain_path(adc_sample, l_cfg.offset, l_cfg.gain);

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			pdiv <= 3'h0;
			gcyc <= 4'h0;
			px <= 11'h000;
		end else begin
			pdiv <= (pdiv == 3'(PAR_DIV - 1)) ? 3'h0 : 3'(pdiv + 3'h1);
			gcyc <= (gcyc == 4'(SER_GROUP - 1)) ? 4'h0 : 4'(gcyc + 4'h1);
			if (row_end || st != ST_RUN) px <= 11'h000;
			else if (need) px <= 11'(px + 11'h001);
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			adc_take <= 1'b0;
			t_v <= 1'b0;
			t_emb <= 1'b0;
			t_bot <= 1'b0;
			t_fr <= 1'b0;
			t_px <= 11'h000;
			t_lane <= 2'h0;
			v2 <= 1'b0;
			d2 <= 1'b0;
			fr2 <= 1'b0;
			w2 <= 12'h000;
			lin2 <= 12'h000;
			lane2 <= 2'h0;
		end else begin
			adc_take <= need && (kind == ROW_DATA);
			t_v <= need;
			t_emb <= kind != ROW_DATA;
			t_bot <= kind == ROW_BOT;
			t_fr <= pix_row;
			t_px <= px;
			t_lane <= gcyc[1:0];
			v2 <= t_v;
			d2 <= t_v && !t_emb;
			fr2 <= t_fr;
			lane2 <= t_lane;
			lin2 <= proc_w;
			if (t_emb) w2 <= emb_w;
			else w2 <= l_cfg.ctrl.comp10 ? compress(proc_w) : proc_w;
		end
	end

	// histogram of four brightness bins, snapshot at each frame start
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			for (int i = 0; i < 4; i++) begin
				hist[i] <= 20'h0_0000;
				hist_snap[i] <= 20'h0_0000;
			end
		end else if ((st == ST_RUN) && (slot == 12'h000) && (col == 16'h0000)) begin
			for (int i = 0; i < 4; i++) begin
				hist_snap[i] <= hist[i];
				hist[i] <= 20'h0_0000;
			end
		end else if (d2) begin
			hist[lin2[11:10]] <= 20'(hist[lin2[11:10]] + 20'h0_0001);
		end
	end

	// ------------------------------------------------------------
	// output ports
	// ------------------------------------------------------------
	logic [11:0] gbuf [LANES];
	logic [11:0] sh [LANES];
	logic [11:0] next_sh [LANES];
	logic grp_v, ser_load;

	assign ser_load = !l_cfg.ctrl.parallel && (gcyc == 4'(SER_GROUP - 1));

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			if (ser_load) next_sh[i] = l_cfg.ctrl.comp10 ? {gbuf[i][9:0], 2'b00} : gbuf[i];
			else next_sh[i] = {sh[i][10:0], 1'b0};
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			grp_v <= 1'b0;
			for (int i = 0; i < LANES; i++) begin
				gbuf[i] <= 12'h000;
				sh[i] <= 12'h000;
			end
			serial_data_lane_neg <= '1;
			serial_lane_clock_pos <= 1'b0;
			serial_lane_clock_neg <= 1'b1;
		end else begin
			for (int i = 0; i < LANES; i++) begin
				sh[i] <= next_sh[i];
				serial_data_lane_neg[i] <= ~next_sh[i][11];
				if (ser_load) gbuf[i] <= 12'h000;
				else if (v2 && lane2 == 2'(i)) gbuf[i] <= w2;
			end
			if (ser_load) grp_v <= 1'b0;
			else if (v2) grp_v <= 1'b1;
			serial_lane_clock_pos <= l_cfg.ctrl.parallel ? 1'b0 : ~serial_lane_clock_pos;
			serial_lane_clock_neg <= l_cfg.ctrl.parallel ? 1'b1 : serial_lane_clock_pos;
		end
	end

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		assign serial_data_lane_pos[i] = sh[i][11];
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			par_data <= 12'h000;
			par_oe <= 1'b0;
			parallel_pixel_clock <= 1'b0;
			frame_active <= 1'b0;
			row_active <= 1'b0;
		end else begin
			par_oe <= l_cfg.ctrl.parallel && !oe_s;
			if (!l_cfg.ctrl.parallel) parallel_pixel_clock <= 1'b0;
			else if (pdiv == 3'(PAR_RISE)) parallel_pixel_clock <= 1'b1;
			else if (pdiv == 3'h0) parallel_pixel_clock <= 1'b0;
			if (l_cfg.ctrl.parallel ? (pdiv == 3'(PAR_LOAD)) : ser_load) begin
				frame_active <= fr2;
				row_active <= l_cfg.ctrl.parallel ? v2 : (grp_v || v2);
			end
			if (!l_cfg.ctrl.parallel) par_data <= 12'h000;
			else if (pdiv == 3'(PAR_LOAD)) par_data <= v2 ? w2 : 12'h000;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [10:0] last_read;
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) last_read <= 11'h000;
		else if (row_read_pulse) last_read <= row_read_addr;
	end

	property p_reset_before_read;
		@(posedge link_clk) disable iff (!lrst_n)
		row_read_pulse && !hdr_second && !l_cfg.ctrl.hdr |-> ##1 row_reset_pulse
			&& (row_reset_addr == ((12'(row_read_addr) + 12'(l_cfg.exp_long) >= 12'(ACTIVE_ROWS))
			? 11'(row_read_addr + l_cfg.exp_long - 11'(ACTIVE_ROWS))
			: 11'(row_read_addr + l_cfg.exp_long)));
	endproperty
	a_reset_before_read: assert property (p_reset_before_read) else $error("bad reset row");
	property p_row_order;
		@(posedge link_clk) disable iff (!lrst_n)
		$rose(row_read_pulse) && !l_cfg.ctrl.hdr && row_read_addr != 11'h000 |->
			row_read_addr == 11'(last_read + 11'h001);
	endproperty
	a_row_order: assert property (p_row_order) else $error("rows out of order");
	property p_par_rate;
		@(posedge link_clk) disable iff (!lrst_n)
		adc_take && l_cfg.ctrl.parallel && $stable(l_cfg) |=> !adc_take [*5];
	endproperty
	a_par_rate: assert property (p_par_rate) else $error("pixel rate too high");
	property p_pclk_stable;
		@(posedge link_clk) disable iff (!lrst_n)
		$rose(parallel_pixel_clock) |-> $stable(par_data) && $stable(row_active);
	endproperty
	a_pclk_stable: assert property (p_pclk_stable) else $error("data moved at clock");
	property p_lane_diff;
		@(posedge link_clk) disable iff (!lrst_n)
		serial_data_lane_neg == ~serial_data_lane_pos
			&& serial_lane_clock_neg == ~serial_lane_clock_pos;
	endproperty
	a_lane_diff: assert property (p_lane_diff) else $error("lane pair not complementary");
	property p_ddr_clock;
		@(posedge link_clk) disable iff (!lrst_n)
		!l_cfg.ctrl.parallel ##1 !l_cfg.ctrl.parallel |-> serial_lane_clock_pos
			!= $past(serial_lane_clock_pos);
	endproperty
	a_ddr_clock: assert property (p_ddr_clock) else $error("lane clock stalled");
	property p_comp_range;
		@(posedge link_clk) disable iff (!lrst_n)
		d2 && l_cfg.ctrl.comp10 && $stable(l_cfg) |-> w2 < 12'h400;
	endproperty
	a_comp_range: assert property (p_comp_range) else $error("compressed word too wide");
	property p_unity_gain;
		@(posedge link_clk) disable iff (!lrst_n)
		adc_take && l_cfg.gain == GAIN_RST && l_cfg.offset == 12'h000 && !l_cfg.ctrl.comp10
			##1 $stable(l_cfg) |=> w2 == $past(adc_sample);
	endproperty
	a_unity_gain: assert property (p_unity_gain) else $error("gain path altered sample");
	property p_trigger_start;
		@(posedge link_clk) disable iff (!lrst_n)
		st == ST_IDLE && l_cfg.ctrl.trig_mode && trig_edge && $stable(l_cfg) |=> st == ST_RUN;
	endproperty
	a_trigger_start: assert property (p_trigger_start) else $error("trigger ignored");
	property p_oe_off;
		@(posedge link_clk) disable iff (!lrst_n)
		oe_s |=> !par_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driving while disabled");
	c_trig_frame: cover property (@(posedge link_clk) disable iff (!lrst_n)
		l_cfg.ctrl.trig_mode && st == ST_RUN && frame_end);
	c_hdr_second: cover property (@(posedge link_clk) disable iff (!lrst_n)
		row_read_pulse && hdr_second);
	c_emb_row: cover property (@(posedge link_clk) disable iff (!lrst_n) v2 && t_bot);
	c_pclk: cover property (@(posedge link_clk) disable iff (!lrst_n)
		$rose(parallel_pixel_clock) && row_active);
endmodule : isro_top

// >>> tb/isro_isp_model.sv
// far-side pixel receiver model on the parallel port
`timescale 1ns/1ps
module isro_isp_model (
	input wire logic parallel_pixel_clock,
	input wire logic frame_active,
	input wire logic row_active,
	input wire logic par_oe,
	input wire logic [isro_pkg::WORD_BITS-1:0] par_data,
	output logic [isro_pkg::WORD_BITS-1:0] last_word,
	output int unsigned n_pix
);
	import isro_pkg::*;
	initial n_pix = 0;
	// words are taken on the pixel clock rising edge, inside a row only
	always @(posedge parallel_pixel_clock) begin
		if (frame_active && row_active && par_oe) begin
			last_word <= par_data;
			n_pix <= n_pix + 1;
		end
	end
endmodule : isro_isp_model

// >>> tb/tb.sv
// register and pixel port bench of the readout block
`timescale 1ns/1ps
`define chk(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
	$display("Error %s exp %h got %h", nm, e, s); end end
module tb;
	import isro_pkg::*;
	logic hclk = 1'b0, link_clk = 1'b0, hresetn = 1'b0, b;
	logic hsel = 1'b0, hwrite = 1'b0, trigger_pin = 1'b0, output_enable_n = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [WORD_BITS-1:0] adc_sample = 12'h123, par_data, last_word;
	logic hreadyout, hresp, par_oe, pclk, fa, ra, lcp, lcn, pll_en, rcm;
	logic [LANES-1:0] ldp, ldn;
	logic [15:0] f0;
	int unsigned n_pix, n0;
	int n_fail = 0, total_checks = 0;
	always #50 hclk = ~hclk;
	// link clock offset by 1 ns so its edges never meet the bus clock edges
	initial #1 forever #6 link_clk = ~link_clk;
	isro_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.link_clk(link_clk), .trigger_pin(trigger_pin), .output_enable_n(output_enable_n),
		.adc_sample(adc_sample), .adc_take(), .row_reset_pulse(), .row_reset_addr(),
		.row_read_pulse(), .row_read_addr(), .hdr_second(), .par_data(par_data),
		.par_oe(par_oe), .parallel_pixel_clock(pclk), .frame_active(fa), .row_active(ra),
		.serial_data_lane_pos(ldp), .serial_data_lane_neg(ldn), .serial_lane_clock_pos(lcp),
		.serial_lane_clock_neg(lcn), .pll_enable(pll_en), .raised_common_mode_select(rcm));
	isro_isp_model isp_u (.parallel_pixel_clock(pclk), .frame_active(fa), .row_active(ra),
		.par_oe(par_oe), .par_data(par_data), .last_word(last_word), .n_pix(n_pix));
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 100) begin
				n_fail++;
				give_verdict();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : xfer
	task automatic settle();
		int k;
		k = 0;
		do begin
			xfer(1'b0, REG_STATUS, '0);
			k++;
		end while (rd[16] !== 1'b0 && k < 50);
		`chk("in_flight", 1'b0, rd[16])
		if (rd[16] !== 1'b0) give_verdict();
	endtask : settle
	task automatic wait_pix();
		int k;
		n0 = n_pix;
		for (k = 0; k < 20000 && n_pix < n0 + 4; k++) @(posedge hclk);
		`chk("pix_flow", 1'b1, n_pix >= n0 + 4)
		if (n_pix < n0 + 4) give_verdict();
	endtask : wait_pix
	task automatic wait_frame();
		int k;
		xfer(1'b0, REG_STATUS, '0);
		f0 = rd[15:0];
		for (k = 0; k < 100 && rd[15:0] === f0; k++) begin
			repeat (200) @(posedge hclk);
			xfer(1'b0, REG_STATUS, '0);
		end
		`chk("frame_cnt", 1'b1, rd[15:0] !== f0)
		if (rd[15:0] === f0) give_verdict();
	endtask : wait_frame
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, REG_CTRL, '0);
		`chk("ctrl", 32'h0000_0041, rd)
		xfer(1'b0, REG_EXPOSURE, '0);
		`chk("exposure", 32'h0064_03E8, rd)
		xfer(1'b0, REG_GAIN, '0);
		`chk("gain", 32'h0000_0080, rd)
		xfer(1'b0, REG_ROWLEN, '0);
		`chk("rowlen", 32'h0000_19C8, rd)
		xfer(1'b0, 8'h20, '0);
		`chk("unmapped", 32'h0000_0000, rd)
		`chk("hresp", 1'b0, hresp)
		`chk("pll", 1'b1, pll_en)
		`chk("lane_neg", ~ldp, ldn)
		`chk("lclk_neg", ~lcp, lcn)
		@(posedge link_clk);
		#1 b = lcp;
		@(posedge link_clk);
		#1 `chk("lclk_ddr", ~b, lcp)
		@(posedge hclk);
		xfer(1'b1, REG_ROWLEN, 32'h0000_0028);
		xfer(1'b1, REG_CTRL, 32'h0000_00D1);
		settle();
		`chk("raise_cm", 1'b1, rcm)
		xfer(1'b0, REG_CTRL, '0);
		`chk("ctrl_rb", 32'h0000_00D1, rd)
		wait_pix();
		`chk("pix_unity", 12'h123, last_word)
		`chk("oe_on", 1'b1, par_oe)
		xfer(1'b1, REG_GAIN, 32'h0000_0100);
		settle();
		wait_pix();
		`chk("pix_gain2", 12'h246, last_word)
		xfer(1'b1, REG_CTRL, 32'h0000_00D9);
		settle();
		wait_pix();
		`chk("pix_comp10", 12'h223, last_word)
		wait_frame();
		xfer(1'b1, REG_CTRL, 32'h0000_00FF);
		settle();
		wait_frame();
		repeat (20) @(posedge hclk);
		`chk("trig_hold", 1'b0, fa)
		trigger_pin <= 1'b1;
		repeat (5) @(posedge hclk);
		`chk("trig_start", 1'b1, fa)
		trigger_pin <= 1'b0;
		output_enable_n <= 1'b1;
		repeat (10) @(posedge hclk);
		`chk("oe_off", 1'b0, par_oe)
		give_verdict();
	end
endmodule : tb
